// ### core/dmr_ctrl.sv
// Controller end: AHB-Lite slave registers, issues link commands with spacing.
// Assumes one shared clock; device is dmr_device on the same interface.
`include "dmr_defines.svh"
`default_nettype none
module dmr_ctrl
	import dmr_pkg::*;
#(
	parameter int DLL_LOCK = `DMR_DLL_LOCK_CYC,
	parameter int MOD_GAP  = 12
) (
	// AHB-Lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Link
	dmr_link_if.ctl          lnk
);
	typedef enum {ST_IDLE, ST_GAP} dmr_cst_t;
	dmr_cst_t    st_r;
	logic        ph_wr_r, ph_v_r;
	logic [7:0]  ph_a_r;
	logic [31:0] ctrl_r;           // [2:0] bank, [16:0] in wdata
	logic [16:0] wdat_r;
	logic [12:0] gap_r;            // Command spacing counter
	logic [12:0] lock_r;           // Cycles since DLL reset
	logic [7:0]  rdat_r;
	logic        busy_r;
	wire         ap = hsel && htrans[1];
	wire         cmd_go = ph_v_r && ph_wr_r && ph_a_r == `DMR_REG_CMD && st_r == ST_IDLE;
	wire  [2:0]  opc = hwdata[2:0];
	// Hold reads until DLL lock completes
	wire         rd_block = opc == 3'(DMR_READ) && lock_r != 13'(DLL_LOCK);

	// Address phase capture; stall while a command waits its spacing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_v_r <= 1'b0; ph_wr_r <= 1'b0; ph_a_r <= 8'h00;
		end else if (hreadyout) begin
			ph_v_r <= ap; ph_wr_r <= hwrite; ph_a_r <= haddr;
		end
	end
	assign hreadyout = !(ph_v_r && ph_wr_r && ph_a_r == `DMR_REG_CMD && (st_r != ST_IDLE || rd_block));
	assign hresp     = 1'b0;

	// Register writes and command issue with MRD/MOD spacing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= ST_IDLE; gap_r <= 13'h0; wdat_r <= 17'h0; ctrl_r <= 32'h0;
			lock_r <= 13'h0; lnk.cmd <= DMR_NOP; lnk.ba <= 3'h0; lnk.addr <= 17'h0;
		end else begin
			lnk.cmd <= DMR_NOP;
			if (lock_r != 13'(DLL_LOCK))
				lock_r <= lock_r + 13'h1;
			if (ph_v_r && ph_wr_r && ph_a_r == `DMR_REG_WDATA)
				wdat_r <= hwdata[16:0];
			if (ph_v_r && ph_wr_r && ph_a_r == `DMR_REG_CTRL)
				ctrl_r <= hwdata;
			case (st_r)
				ST_IDLE: begin
					if (cmd_go && !rd_block) begin
						lnk.cmd  <= dmr_cmd_t'(opc);
						lnk.ba   <= ctrl_r[2:0];
						// Force reserved MR1 bits to zero
						lnk.addr <= (opc == 3'(DMR_MRS) && ctrl_r[2:0] == `DMR_BA_MR1) ?
						            (wdat_r & ~`DMR_MR1_RSVD) : wdat_r;
						if (opc == 3'(DMR_MRS) && ctrl_r[2:0] == `DMR_BA_MR0 && wdat_r[`DMR_DLLRST_BIT])
							lock_r <= 13'h0;
						gap_r <= 13'(MOD_GAP);
						st_r  <= ST_GAP;
					end
				end
				ST_GAP: begin
					gap_r <= gap_r - 13'h1;
					if (gap_r == 13'h1)
						st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Readback and status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdat_r <= 8'h00; busy_r <= 1'b0;
		end else begin
			busy_r <= st_r != ST_IDLE;
			if (lnk.dq_ctl_oe == 1'b0)
				rdat_r <= lnk.dq;
		end
	end
	assign hrdata = (ph_a_r == `DMR_REG_CTRL)  ? ctrl_r :
	                (ph_a_r == `DMR_REG_WDATA) ? {15'h0, wdat_r} :
	                (ph_a_r == `DMR_REG_STAT)  ? {30'h0, lock_r == 13'(DLL_LOCK), busy_r} :
	                (ph_a_r == `DMR_REG_RDATA) ? {24'h0, rdat_r} : 32'h0;
	assign lnk.dq_ctl    = ctrl_r[15:8];
	assign lnk.dq_ctl_oe = ctrl_r[16];
endmodule : dmr_ctrl
`default_nettype wire

// ### core/dmr_device.sv
// Device end: mode registers, burst order, read latency, DLL state.
// Assumes the controller keeps command spacing rules; data is one byte per beat.
//
// Added by the designer: the AHB-Lite slave port and the address map.
`include "dmr_defines.svh"
`default_nettype none
module dmr_device
	import dmr_pkg::*;
#(
	parameter int DLL_LOCK = `DMR_DLL_LOCK_CYC
) (
	// Link
	dmr_link_if.dev   lnk,
	// Observation of internal state
	output logic [16:0] mr0_value,
	output logic [16:0] mr1_value,
	output logic [3:0]  cas_lat,
	output logic [3:0]  wr_rec,
	output logic        dll_on,
	output logic        dll_locked,
	output logic        wlev_all_rtt,
	output logic        odt_allowed,
	// Array write port (column, data)
	output logic        wr_valid,
	output logic [2:0]  wr_col,
	output logic [7:0]  wr_data
);
	// Address captured into the beat column for beat i of start s
	function automatic logic [2:0] beat_col(input logic [2:0] s, input logic [2:0] i, input logic il);
		logic [2:0] c;
		c = 3'h0;
		if (il)
			c = s ^ i;
		else
			c = {s[2] ^ i[2], 2'(s[1:0] + i[1:0])};
		return c;
	endfunction : beat_col

	// Decode CL field: 1..6 maps to 5..10
	function automatic logic [3:0] cl_decode(input logic [2:0] f);
		return 4'(f) + 4'h4;
	endfunction : cl_decode

	logic [16:0] mr0_r, mr1_r;      // Mode registers
	logic        dll_en_r;          // DLL enable bit from MR1
	logic        sr_r;              // In self refresh
	logic        ppd_r;             // In precharge power-down
	logic [12:0] lock_cnt_r;        // Cycles since DLL reset
	logic [7:0]  ts_r [0:15];       // Data memory of sixteen columns (low half used)
	// Read pipeline
	logic [3:0]  rd_dly_r;          // Remaining latency
	logic        rd_pend_r;         // Read waiting on latency
	logic        rd_act_r;          // Beats being driven
	logic [2:0]  beat_r;            // Beat index
	logic [2:0]  start_r;           // Start column
	logic        chop_r;            // Chop four
	logic        il_r;              // Interleaved
	// Write pipeline
	logic        wr_act_r;
	logic [2:0]  wbeat_r;
	logic        wchop_r;
	logic [2:0]  wbase_r;
	logic [7:0]  dq_r;

	wire         is_mrs   = lnk.cmd == DMR_MRS;
	wire         is_rd    = lnk.cmd == DMR_READ;
	wire         is_wr    = lnk.cmd == DMR_WRITE;
	wire  [1:0]  bl_fld   = mr0_r[`DMR_BL_HI:`DMR_BL_LO];
	// Burst chop when fixed chop, or on-the-fly with A12 low
	wire         cmd_chop = (bl_fld == `DMR_BL_CHOP4) || (bl_fld == `DMR_BL_OTF && !lnk.addr[12]);
	wire  [3:0]  cl_eff   = dll_en_r ? cl_decode(mr0_r[`DMR_CL_HI:`DMR_CL_LO]) : `DMR_DLL_OFF_LAT;
	// Beat that the output register will show after this edge: zero when a burst starts, else the next one.
	// Looking one beat ahead keeps the registered data in step with the driver enable.
	wire  [2:0]  rd_nbeat = rd_act_r ? beat_r + 3'h1 : 3'h0;
	wire  [2:0]  rd_col   = beat_col(start_r, rd_nbeat, il_r);

	// Mode register capture, bank address selects target
	always_ff @(posedge lnk.hclk or negedge lnk.hresetn) begin
		if (!lnk.hresetn) begin
			mr0_r <= `DMR_MR0_RESET;
			mr1_r <= `DMR_MR1_RESET;
		end else if (is_mrs && lnk.ba == `DMR_BA_MR0) begin
			mr0_r <= lnk.addr;
		end else if (is_mrs && lnk.ba == `DMR_BA_MR1) begin
			mr1_r <= lnk.addr;
		end else begin
			mr0_r[`DMR_DLLRST_BIT] <= 1'b0; // Self-clear once reset started
		end
	end

	// DLL state: enable bit, self refresh, power-down, lock counter
	always_ff @(posedge lnk.hclk or negedge lnk.hresetn) begin
		if (!lnk.hresetn) begin
			dll_en_r   <= 1'b0;
			sr_r       <= 1'b0;
			ppd_r      <= 1'b0;
			lock_cnt_r <= 13'h0;
		end else begin
			if (is_mrs && lnk.ba == `DMR_BA_MR1)
				dll_en_r <= lnk.addr[`DMR_DLLEN_BIT];
			if (lnk.cmd == DMR_SRE)
				sr_r <= 1'b1;
			if (lnk.cmd == DMR_SRX)
				sr_r <= 1'b0;
			if (lnk.cmd == DMR_PDE)
				ppd_r <= 1'b1;
			if (lnk.cmd == DMR_PDX)
				ppd_r <= 1'b0;
			// Restart lock on DLL reset or self refresh exit with DLL enabled
			if ((is_mrs && lnk.ba == `DMR_BA_MR0 && lnk.addr[`DMR_DLLRST_BIT]) ||
			    (lnk.cmd == DMR_SRX && dll_en_r))
				lock_cnt_r <= 13'h0;
			else if (dll_on && lock_cnt_r != 13'(DLL_LOCK))
				lock_cnt_r <= lock_cnt_r + 13'h1;
		end
	end

	// Read: capture at command, wait CL, then drive beats
	always_ff @(posedge lnk.hclk or negedge lnk.hresetn) begin
		if (!lnk.hresetn) begin
			rd_pend_r <= 1'b0;
			rd_act_r  <= 1'b0;
			rd_dly_r  <= 4'h0;
			beat_r    <= 3'h0;
			start_r   <= 3'h0;
			chop_r    <= 1'b0;
			il_r      <= 1'b0;
			dq_r      <= 8'h00;
		end else begin
			if (is_rd) begin
				rd_pend_r <= 1'b1;
				rd_dly_r  <= cl_eff - 4'h1;
				start_r   <= lnk.addr[2:0];
				chop_r    <= cmd_chop;
				il_r      <= mr0_r[`DMR_BT_BIT];
			end else if (rd_pend_r && rd_dly_r != 4'h0) begin
				rd_dly_r <= rd_dly_r - 4'h1;
			end else if (rd_pend_r) begin
				rd_pend_r <= 1'b0;
				rd_act_r  <= 1'b1;
				beat_r    <= 3'h0;
			end else if (rd_act_r) begin
				beat_r   <= beat_r + 3'h1;
				rd_act_r <= beat_r != 3'h7; // Chop still occupies eight slots
			end
			dq_r <= ts_r[{1'b0, rd_col}];
		end
	end

	// Write: low column bits ignored, ascending from nibble base
	always_ff @(posedge lnk.hclk or negedge lnk.hresetn) begin
		if (!lnk.hresetn) begin
			wr_act_r <= 1'b0;
			wbeat_r  <= 3'h0;
			wchop_r  <= 1'b0;
			wbase_r  <= 3'h0;
		end else if (is_wr) begin
			wr_act_r <= 1'b1;
			wbeat_r  <= 3'h0;
			wchop_r  <= cmd_chop;
			wbase_r  <= cmd_chop ? {lnk.addr[2], 2'h0} : 3'h0;
		end else if (wr_act_r) begin
			wbeat_r  <= wbeat_r + 3'h1;
			wr_act_r <= wbeat_r != (wchop_r ? 3'h3 : 3'h7);
		end
	end

	// Column storage: written data lands here for readback
	always_ff @(posedge lnk.hclk) begin
		if (wr_act_r)
			ts_r[{1'b0, wr_col}] <= lnk.dq;
	end

	assign wr_col  = wbase_r + wbeat_r;
	assign wr_valid = wr_act_r;
	assign wr_data  = lnk.dq;

	// Drive data while a beat slot is live; chop tri-states upper slots; Q-off forces tri-state
	wire drv = rd_act_r && !(chop_r && beat_r[2]) && !mr1_r[`DMR_QOFF_BIT];
	assign lnk.dq_dev     = dq_r;
	assign lnk.dq_dev_oe  = drv;
	assign lnk.dqs_dev_oe = drv;

	// DLL runs if enabled, not in self refresh, and not in PPD with slow-exit setting
	assign dll_on       = dll_en_r && !sr_r && !(ppd_r && !mr0_r[`DMR_PPD_BIT]);
	assign dll_locked   = dll_on && lock_cnt_r == 13'(DLL_LOCK);
	assign mr0_value    = mr0_r;
	assign mr1_value    = mr1_r;
	assign cas_lat      = cl_eff;
	// Write recovery codes 1..7 -> 5,6,7,8,10,12,14
	assign wr_rec       = (mr0_r[`DMR_WR_HI:`DMR_WR_LO] == 3'h5) ? 4'ha :
	                      (mr0_r[`DMR_WR_HI:`DMR_WR_LO] == 3'h6) ? 4'hc :
	                      (mr0_r[`DMR_WR_HI:`DMR_WR_LO] == 3'h7) ? 4'he : 4'(mr0_r[`DMR_WR_HI:`DMR_WR_LO]) + 4'h4;
	// Leveling with bit 12 set allows all nominal termination
	assign wlev_all_rtt = mr1_r[`DMR_WLEV_BIT] && mr1_r[`DMR_QOFF_BIT];
	assign odt_allowed  = dll_en_r;
endmodule : dmr_device
`default_nettype wire

// ### shared/dmr_defines.svh
// Constants for the mode-register burst-order block: field positions, codes, timing counts.
// Assumes a single 10 MHz clock shared by both ends.
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH
`define DMR_BL_LO        0
`define DMR_BL_HI        1
`define DMR_BT_BIT       3
`define DMR_CL_LO        4
`define DMR_CL_HI        6
`define DMR_DLLRST_BIT   8
`define DMR_WR_LO        9
`define DMR_WR_HI        11
`define DMR_PPD_BIT      12
`define DMR_DLLEN_BIT    0
`define DMR_WLEV_BIT     7
`define DMR_QOFF_BIT     12
`define DMR_MR1_RSVD     17'h12500
`define DMR_BL_FIXED8    2'h0
`define DMR_BL_OTF       2'h1
`define DMR_BL_CHOP4     2'h2
`define DMR_BA_MR0       3'h0
`define DMR_BA_MR1       3'h1
`define DMR_MR0_RESET    17'h00000
`define DMR_MR1_RESET    17'h00000
`define DMR_DLL_OFF_LAT  4'h6
`define DMR_DLL_LOCK_NS  51200
`define DMR_CLK_NS       100
`define DMR_DLL_LOCK_CYC (`DMR_DLL_LOCK_NS / `DMR_CLK_NS)
`define DMR_WR_NS        15
`define DMR_REG_CTRL     8'h00
`define DMR_REG_CMD      8'h04
`define DMR_REG_STAT     8'h08
`define DMR_REG_RDATA    8'h0c
`define DMR_REG_WDATA    8'h10
`endif

// ### shared/dmr_link_if.sv
// Link between the memory-side device and its controller.
// Assumes one shared clock and reset; DQ is two-way, resolved here.
`default_nettype none
interface dmr_link_if (
	input wire logic hclk,
	input wire logic hresetn
);
	import dmr_pkg::*;
	dmr_cmd_t    cmd;       // Command this cycle
	logic [2:0]  ba;        // Bank address
	logic [16:0] addr;      // Address / mode value
	logic [7:0]  dq_dev;    // Device data drive
	logic        dq_dev_oe; // Device drives data
	logic        dqs_dev_oe;// Device drives strobe
	logic [7:0]  dq_ctl;    // Controller data drive
	logic        dq_ctl_oe; // Controller drives data
	logic [7:0]  dq;        // Resolved wire level
	assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : 8'h00);
	modport dev (input hclk, hresetn, cmd, ba, addr, dq, output dq_dev, dq_dev_oe, dqs_dev_oe);
	modport ctl (input hclk, hresetn, dq, output cmd, ba, addr, dq_ctl, dq_ctl_oe);
endinterface : dmr_link_if
`default_nettype wire

// ### shared/dmr_pkg.sv
// Types shared by both ends of the mode-register link.
// Assumes dmr_defines.svh for numeric constants.
`default_nettype none
package dmr_pkg;
	// Commands the controller places on the link
	typedef enum logic [2:0] {DMR_NOP, DMR_MRS, DMR_READ, DMR_WRITE, DMR_SRE, DMR_SRX, DMR_PDE, DMR_PDX} dmr_cmd_t;
endpackage : dmr_pkg
`default_nettype wire

// ### tb/dmr_link_assertions.sv
// Checker: link command spacing, read lock wait, read burst timing and drivers.
// Assumes it watches the link that joins dmr_ctrl and dmr_device.
`include "dmr_defines.svh"
`default_nettype none
module dmr_link_assertions
	import dmr_pkg::*;
#(
	parameter int DLL_LOCK = 16,
	parameter int MOD_GAP  = 12
) (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Command lines
	input wire dmr_cmd_t    cmd,
	input wire logic [2:0]  ba,
	input wire logic [16:0] addr,
	// Device drivers
	input wire logic        dq_dev_oe,
	input wire logic        dqs_dev_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [2:0]  clf_r;  // Latency code held by the device
	logic [1:0]  blf_r;  // Length code held by the device
	logic        chop_r; // Last read was four beats
	logic [15:0] gap_r;  // Cycles since last command
	logic [15:0] lck_r;  // Cycles since last DLL reset
	logic [7:0]  rd_r;   // Cycles since last read
	wire         rd_cmd = cmd == DMR_READ;
	wire         mr0_wr = cmd == DMR_MRS && ba == `DMR_BA_MR0;
	wire         is_cmd = cmd != DMR_NOP;
	// Counters saturate so a long idle spell cannot wrap into a false pass
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clf_r <= 3'h0;
			blf_r <= 2'h0;
			chop_r <= 1'b0;
			gap_r <= 16'(MOD_GAP);
			lck_r <= 16'h0;
			rd_r <= 8'h0;
		end else begin
			if (mr0_wr) begin
				clf_r <= addr[6:4];
				blf_r <= addr[1:0];
			end
			if (rd_cmd) begin
				chop_r <= blf_r == `DMR_BL_CHOP4 || (blf_r == `DMR_BL_OTF && !addr[12]);
			end
			gap_r <= is_cmd ? 16'h0 : gap_r + {15'h0, ~&gap_r};
			lck_r <= (mr0_wr && addr[`DMR_DLLRST_BIT]) ? 16'h0 : lck_r + {15'h0, ~&lck_r};
			rd_r <= rd_cmd ? 8'h1 : rd_r + {7'h0, rd_r != 8'h0 && ~&rd_r};
		end
	end
	// Beats stand back to back, then the data driver lets go
	sequence s_chop_beats;
		dq_dev_oe [*4] ##1 !dq_dev_oe;
	endsequence
	sequence s_full_beats;
		dq_dev_oe [*8] ##1 !dq_dev_oe;
	endsequence
	chk_cmd_spacing: assert property (is_cmd |-> gap_r >= 16'(MOD_GAP))
		else $error("link commands too close");
	chk_read_lock: assert property (rd_cmd |-> lck_r >= 16'(DLL_LOCK - 1))
		else $error("read before lock time");
	chk_first_beat: assert property ($rose(dq_dev_oe) |-> rd_r == {5'h0, clf_r} + 8'h5)
		else $error("first read beat off time");
	chk_chop_len: assert property ($rose(dq_dev_oe) && chop_r |-> s_chop_beats)
		else $error("short burst length wrong");
	chk_full_len: assert property ($rose(dq_dev_oe) && !chop_r |-> s_full_beats)
		else $error("long burst length wrong");
	chk_strobe_with: assert property (dq_dev_oe |-> dqs_dev_oe)
		else $error("data driven without strobe");
	chk_strobe_off: assert property ($fell(dq_dev_oe) |-> ##[0:1] !dqs_dev_oe)
		else $error("strobe left driven");
	chk_rsvd_zero: assert property (cmd == DMR_MRS && ba == `DMR_BA_MR1 |-> (addr & `DMR_MR1_RSVD) == 17'h0)
		else $error("reserved bits set");
endmodule : dmr_link_assertions
`default_nettype wire

// ### tb/testbench.sv
// Bench: AHB-Lite master drives the controller, which drives the device.
// Assumes a 10 MHz clock and a shortened DLL lock count.
`include "dmr_defines.svh"
`default_nettype none
module testbench
	import dmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LOCK = 16; // Short lock count keeps the run brief
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dll_on, locked, wlev, odt, wv, a;
	logic [7:0]  haddr, wdat;
	logic [1:0]  htrans;
	logic [2:0]  hsize, wcol;
	logic [31:0] hwdata, hrdata, rd;
	logic [16:0] mr0, mr1, on;
	logic [3:0]  cl, wr;
	logic [15:0] wq[$];   // Write beats at the array port
	logic [7:0]  rq[$];   // Read beats on the data wire
	logic [4:0]  rt[4] = '{5'h0d, 5'h06, 5'h1b, 5'h11}; // Type, long, column
	int          n_mismatch, compares, cyc;
	dmr_link_if u_dmr_link_if (.hclk(hclk), .hresetn(hresetn));
	dmr_device #(.DLL_LOCK(LOCK)) u_dmr_device (.lnk(u_dmr_link_if), .mr0_value(mr0), .mr1_value(mr1),
		.cas_lat(cl), .wr_rec(wr), .dll_on(dll_on), .dll_locked(locked), .wlev_all_rtt(wlev),
		.odt_allowed(odt), .wr_valid(wv), .wr_col(wcol), .wr_data(wdat));
	dmr_ctrl #(.DLL_LOCK(LOCK), .MOD_GAP(12)) u_dmr_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .lnk(u_dmr_link_if));
	dmr_link_assertions #(.DLL_LOCK(LOCK), .MOD_GAP(12)) u_dmr_link_assertions (.hclk(hclk),
		.hresetn(hresetn), .cmd(u_dmr_link_if.cmd), .ba(u_dmr_link_if.ba), .addr(u_dmr_link_if.addr),
		.dq_dev_oe(u_dmr_link_if.dq_dev_oe), .dqs_dev_oe(u_dmr_link_if.dqs_dev_oe));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// Collect beats; a hang is cut short by the cycle ceiling
	always @(posedge hclk) begin
		cyc++;
		if (u_dmr_link_if.dq_dev_oe === 1'b1) rq.push_back(u_dmr_link_if.dq);
		if (wv === 1'b1) wq.push_back({wdat, 5'h0, wcol});
		if (cyc == 6000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("compares %0d, n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// One single-word transfer; each phase waits for hready
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// Value, bank and data byte, then the opcode; the controller holds spacing
	task automatic issue(input dmr_cmd_t op, input logic [2:0] b, input logic [16:0] v, input logic [8:0] dqd);
		ahb(1'b1, `DMR_REG_WDATA, {15'h0, v});
		ahb(1'b1, `DMR_REG_CTRL, {15'h0, dqd, 5'h0, b});
		ahb(1'b1, `DMR_REG_CMD, {29'h0, op});
		repeat (10) @(posedge hclk);
	endtask : issue
	task automatic mrs(input logic [2:0] b, input logic [16:0] v);
		issue(DMR_MRS, b, v, 9'h0);
	endtask : mrs
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		check(mr0 | mr1, 32'h0);
		ahb(1'b0, 8'h20, 32'h0);
		check(hresp, 32'h0);
		// Learn which enable level runs the DLL, then exercise both
		mrs(3'h1, 17'h0);
		a = dll_on;
		mrs(3'h1, 17'h1);
		check(a ^ dll_on, 32'h1);
		on = {16'h0, dll_on};
		mrs(3'h1, on ^ 17'h1);
		check({cl, odt}, {4'h6, 1'b0});
		issue(DMR_SRE, 3'h0, 17'h0, 9'h0);
		issue(DMR_SRX, 3'h0, 17'h0, 9'h0);
		check(dll_on, 32'h0);
		mrs(3'h1, on | 17'h1080);
		check(wlev, 32'h1);
		mrs(3'h1, on | 17'h0080);
		check(wlev, 32'h0);
		mrs(3'h1, on);
		issue(DMR_SRE, 3'h0, 17'h0, 9'h0);
		check(dll_on, 32'h0);
		issue(DMR_SRX, 3'h0, 17'h0, 9'h0);
		check({dll_on, locked}, 32'h2);
		for (int f = 1; f < 7; f++) begin
			mrs(3'h0, 17'(f * 'h210));
			check(cl, f + 4);
			check(wr, f < 5 ? f + 4 : f * 2);
			check(mr0, f * 'h210);
		end
		check(32'(wr * `DMR_CLK_NS >= `DMR_WR_NS), 32'h1);
		for (int p = 0; p < 2; p++) begin
			mrs(3'h0, p ? 17'h1211 : 17'h0211);
			issue(DMR_PDE, 3'h0, 17'h0, 9'h0);
			check(dll_on, p);
			issue(DMR_PDX, 3'h0, 17'h0, 9'h0);
		end
		// Low column bits must not steer writes
		wq.delete();
		issue(DMR_WRITE, 3'h0, 17'h1006, 9'h111);
		issue(DMR_WRITE, 3'h0, 17'h0001, 9'h122);
		repeat (16) @(posedge hclk);
		check(32'(wq.size()), 32'd12);
		foreach (wq[j]) check(wq[j], {j < 8 ? 8'h11 : 8'h22, 5'h0, j[2:0]});
		mrs(3'h0, 17'h0311);
		check({mr0[8], locked}, 32'h0);
		foreach (rt[i]) begin
			mrs(3'h0, 17'h0211 | {13'h0, rt[i][4], 3'h0});
			rq.delete();
			issue(DMR_READ, 3'h0, {4'h0, rt[i][3], 9'h0, rt[i][2:0]}, 9'h0);
			repeat (16) @(posedge hclk);
			check(32'(rq.size()), rt[i][3] ? 8 : 4);
			foreach (rq[j]) check(rq[j], rt[i][2] ^ (j > 3) ? 8'h11 : 8'h22);
		end
		check(locked, 32'h1);
		check(mr1, on);
		hresetn <= 1'b0;
		@(posedge hclk);
		check(mr0 | mr1, 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
